// ### hdl/mid_core.v
// Function
// - Each 13-bit fetched word is one instruction: opcode plus operand fields.
// - An instruction normally completes in one instruction cycle.
// - Writing the program counter register costs one or two cycles per option.
// - Any bit of any register can be tested, and set or cleared except status bits 3 to 7, which writes leave unchanged.
// - Control-space registers are reached only by the control move instructions, to and from the accumulator.
// - Literal is 8 bits for data, 10 bits for call and jump.
// - Sleep clears watchdog, stops the core, updates time-out and power flags.
// - Call pushes next address, loads PC from page bits and literal.
// - Return-with-literal loads literal into accumulator and pops PC.
// - Return from interrupt pops PC and sets global interrupt enable.
// - Decrement-skip writes value minus one, skips on zero, flags kept.
// - Rotate right: bits down, bit 0 to carry, carry to bit 7.
// - Rotate left: bits up, bit 7 to carry, carry to bit 0.
// - Swap to accumulator exchanges nibbles, flags kept.
// - Control read and write only reach implemented indices of both banks.
// - Cycle option 0 gives one cycle, 1 gives two cycles, default 1.
// - Period option 0 gives two clocks, 1 gives four, default 1.
`timescale 1ns/1ps
`include "mid_defs.vh"
module mid_core #(
  parameter PC_W = 12,
  parameter STK_D = 8,
  parameter SP_W = 3
) (
  input wire clk,
  input wire rst_n,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [PC_W-1:0] progAddr,
  input wire [12:0] progData,
  output wire [5:0] regAddr,
  input wire [7:0] regRdata,
  output wire [7:0] regWdata,
  output wire regWe,
  output wire [3:0] ctrlIdx,
  output wire ctrlBank,
  input wire [7:0] ctrlRdata,
  output wire [7:0] ctrlWdata,
  output wire ctrlWe,
  output wire wdtClear,
  output wire sleeping,
  input wire wakeUp,
  output wire intEnable
);
  localparam S_IDLE = 4'b0001;
  localparam S_RUN = 4'b0010;
  localparam S_STALL = 4'b0100;
  localparam S_SLEEP = 4'b1000;

  reg [3:0] ctrl_r;
  reg awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  reg [4:0] awAddr_r;
  reg [7:0] wData_r;
  reg wStrb_r;
  reg [1:0] bresp_r, rresp_r;
  reg [31:0] rdata_r;
  reg [3:0] st_r;
  reg [1:0] ph_r;
  reg [12:0] ir_r;
  reg [5:0] regAddr_r;
  reg [3:0] ctrlIdx_r;
  reg [PC_W-1:0] pc_r;
  reg [7:0] acc_r, cont_r, regWdata_r, ctrlWdata_r;
  reg z_r, c_r, dc_r, t_r, p_r, gie_r;
  reg regWe_r, ctrlWe_r, wdtClear_r;
  reg [SP_W-1:0] sp_r;
  reg [PC_W-1:0] stk [0:STK_D-1];

  wire run = ctrl_r[`MID_CTRL_RUN];
  wire cycSel = ctrl_r[`MID_CTRL_CYC];
  wire bank = ctrl_r[`MID_CTRL_BANK];
  // Last phase of an instruction cycle
  wire [1:0] phLast = ctrl_r[`MID_CTRL_PER] ? `MID_PH_LONG : `MID_PH_SHORT;
  wire endCyc = (ph_r == phLast);
  wire fetch = (st_r == S_RUN) && (ph_r == 2'h0);
  wire exec = (st_r == S_RUN) && endCyc;
  wire [7:0] stByte = {3'h0, t_r, p_r, z_r, dc_r, c_r};

  // Opcode and operand fields
  wire [3:0] grp = ir_r[11:8];
  wire [5:0] spec = ir_r[5:0];
  wire [2:0] bitIdx = ir_r[8:6];
  wire [7:0] k8 = ir_r[7:0];
  wire [9:0] k10 = ir_r[9:0];
  // Internal registers answer as general registers
  wire [7:0] rv = (regAddr_r == `MID_REG_PC) ? pc_r[7:0] :
    (regAddr_r == `MID_REG_ST) ? stByte : regRdata;
  wire [PC_W-1:0] pcInc = pc_r + 1'b1;
  wire [PC_W-1:0] pcSkip = pc_r + 2'h2;
  wire [PC_W-1:0] stkTop = stk[sp_r - 1'b1];
  wire [7:0] mask = 8'h01 << bitIdx;

  // Shared adder for add and subtract
  wire isSub = ir_r[12] ? (grp == `MID_L_SUB) : (grp == `MID_G_SUB);
  wire [7:0] opX = ir_r[12] ? k8 : rv;
  wire [7:0] opY = isSub ? ~acc_r : acc_r;
  wire [8:0] sum = {1'b0, opX} + {1'b0, opY} + {8'h00, isSub};
  wire [4:0] hsum = {1'b0, opX[3:0]} + {1'b0, opY[3:0]} + {4'h0, isSub};
  // Valid control register index
  wire crOk = (ctrlIdx_r >= `MID_CR_LO) &&
    (ctrlIdx_r <= (bank ? `MID_CR_HI1 : `MID_CR_HI0));

  reg [7:0] res, accN, daa;
  reg [PC_W-1:0] pcN;
  reg zN, cN, dcN, tN, pN, gieN;
  reg wr, wrCr, push, pop, slp, wdt, stall;
  reg [7:0] contN;

  always @*
  begin
    res = 8'h00;
    accN = acc_r;
    daa = acc_r;
    pcN = pcInc;
    zN = z_r;
    cN = c_r;
    dcN = dc_r;
    tN = t_r;
    pN = p_r;
    gieN = gie_r;
    contN = cont_r;
    wr = 1'b0;
    wrCr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    slp = 1'b0;
    wdt = 1'b0;
    stall = 1'b0;
    if (ir_r[12])
    begin
      if (!ir_r[11])
      begin
        // Call and jump use the 10-bit literal
        pcN = {pc_r[PC_W-1:10], k10};
        push = !ir_r[10];
      end
      else
      begin
        case (grp)
          `MID_L_MOV: accN = k8;
          `MID_L_OR: accN = acc_r | k8;
          `MID_L_AND: accN = acc_r & k8;
          `MID_L_XOR: accN = acc_r ^ k8;
          `MID_L_RETURN_WITH_LITERAL:
          begin
            accN = k8;
            pcN = stkTop;
            pop = 1'b1;
          end
          `MID_L_SUB, `MID_L_ADD:
          begin
            accN = sum[7:0];
            cN = sum[8];
            dcN = hsum[4];
          end
          default: accN = acc_r;
        endcase
        if (grp != `MID_L_MOV && grp != `MID_L_RETURN_WITH_LITERAL)
          zN = (accN == 8'h00);
      end
    end
    else if (ir_r[11])
    begin
      // Bit set, clear and
      case (ir_r[10:9])
        2'h0:
        begin
          res = rv & ~mask;
          wr = 1'b1;
        end
        2'h1:
        begin
          res = rv | mask;
          wr = 1'b1;
        end
        2'h2: if (!rv[bitIdx]) pcN = pcSkip;
        default: if (rv[bitIdx]) pcN = pcSkip;
      endcase
    end
    else if (grp == `MID_G_SPEC)
    begin
      case (ir_r[7:6])
        2'h0:
        begin
          case (spec)
            `MID_OP_NOP: accN = acc_r;
            `MID_OP_DAA:
            begin
              if (acc_r[3:0] > `MID_BCD_NIB || dc_r)
                daa = daa + `MID_DAA_LO;
              if (acc_r > `MID_BCD_BYTE || c_r)
              begin
                daa = daa + `MID_DAA_HI;
                cN = 1'b1;
              end
              accN = daa;
            end
            `MID_OP_CTRL_WORD_WRITE_OP: contN = acc_r;
            `MID_OP_SLEEP:
            begin
              wdt = 1'b1;
              slp = 1'b1;
              tN = 1'b1;
              pN = 1'b0;
            end
            `MID_OP_WATCHDOG_CLEAR_OPCODE:
            begin
              wdt = 1'b1;
              tN = 1'b1;
              pN = 1'b1;
            end
            `MID_OP_ENI: gieN = 1'b1;
            `MID_OP_DISI: gieN = 1'b0;
            `MID_OP_RET, `MID_OP_RETURN_FROM_IRQ:
            begin
              pcN = stkTop;
              pop = 1'b1;
              if (spec == `MID_OP_RETURN_FROM_IRQ)
                gieN = 1'b1;
            end
            `MID_OP_CTRL_WORD_READ_OP: accN = cont_r;
            default:
            begin
              // Control register move, implemented indices only
              if (spec[5:4] == 2'h0)
                wrCr = crOk;
              else if (spec[5:4] == 2'h1 && crOk)
                accN = ctrlRdata;
            end
          endcase
        end
        2'h1:
        begin
          res = acc_r;
          wr = 1'b1;
        end
        2'h2:
        begin
          accN = 8'h00;
          zN = 1'b1;
        end
        default:
        begin
          res = 8'h00;
          wr = 1'b1;
          zN = 1'b1;
        end
      endcase
    end
    else
    begin
      // Register source ops, bit 6 picks register as destination
      case ({grp, ir_r[7]})
        {`MID_G_SUB, 1'b0}, {`MID_G_XADD, 1'b1}:
        begin
          res = sum[7:0];
          cN = sum[8];
          dcN = hsum[4];
        end
        {`MID_G_SUB, 1'b1}, {`MID_G_INC, 1'b1}: res = rv - 1'b1;
        {`MID_G_ORAND, 1'b0}: res = acc_r | rv;
        {`MID_G_ORAND, 1'b1}: res = acc_r & rv;
        {`MID_G_XADD, 1'b0}: res = acc_r ^ rv;
        {`MID_G_MOV, 1'b0}: res = rv;
        {`MID_G_MOV, 1'b1}: res = ~rv;
        {`MID_G_INC, 1'b0}, {`MID_G_SWAP, 1'b1}: res = rv + 1'b1;
        {`MID_G_ROT, 1'b0}:
        begin
          res = {c_r, rv[7:1]};
          cN = rv[0];
        end
        {`MID_G_ROT, 1'b1}:
        begin
          res = {rv[6:0], c_r};
          cN = rv[7];
        end
        default: res = {rv[3:0], rv[7:4]};
      endcase
      if (grp <= `MID_G_MOV || (grp == `MID_G_INC && !ir_r[7]))
        zN = (res == 8'h00);
      if ((grp == `MID_G_INC || grp == `MID_G_SWAP) && ir_r[7] &&
          res == 8'h00)
        pcN = pcSkip;
      if (ir_r[6])
        wr = 1'b1;
      else
        accN = res;
    end
    if (wr && regAddr_r == `MID_REG_PC)
    begin
      pcN = {pc_r[PC_W-1:8], res};
      stall = cycSel;
    end
    if (wr && regAddr_r == `MID_REG_ST)
    begin
      zN = res[`MID_ST_Z];
      cN = res[`MID_ST_C];
      dcN = res[`MID_ST_DC];
    end
  end

  // Core sequencing
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= S_IDLE;
      ph_r <= 2'h0;
      ir_r <= 13'h0000;
      regAddr_r <= 6'h00;
      ctrlIdx_r <= 4'h0;
      pc_r <= {PC_W{1'b0}};
      acc_r <= 8'h00;
      cont_r <= 8'h00;
      {z_r, c_r, dc_r, gie_r} <= 4'h0;
      t_r <= 1'b1;
      p_r <= 1'b1;
      sp_r <= {SP_W{1'b0}};
      regWe_r <= 1'b0;
      regWdata_r <= 8'h00;
      ctrlWe_r <= 1'b0;
      ctrlWdata_r <= 8'h00;
      wdtClear_r <= 1'b0;
    end
    else
    begin
      regWe_r <= 1'b0;
      ctrlWe_r <= 1'b0;
      wdtClear_r <= 1'b0;
      if (st_r == S_RUN || st_r == S_STALL)
        ph_r <= endCyc ? 2'h0 : ph_r + 1'b1;
      else
        ph_r <= 2'h0;
      if (fetch)
      begin
        ir_r <= progData;
        regAddr_r <= progData[5:0];
        ctrlIdx_r <= progData[3:0];
      end
      case (st_r)
        S_IDLE: if (run) st_r <= S_RUN;
        S_RUN:
        begin
          if (exec)
          begin
            pc_r <= pcN;
            acc_r <= accN;
            cont_r <= contN;
            {z_r, c_r, dc_r, t_r, p_r, gie_r} <= {zN, cN, dcN, tN, pN, gieN};
            regWe_r <= wr && regAddr_r != `MID_REG_PC &&
              regAddr_r != `MID_REG_ST;
            regWdata_r <= res;
            ctrlWe_r <= wrCr;
            ctrlWdata_r <= acc_r;
            wdtClear_r <= wdt;
            if (push)
              sp_r <= sp_r + 1'b1;
            else if (pop)
              sp_r <= sp_r - 1'b1;
            if (slp)
              st_r <= S_SLEEP;
            else if (stall)
              st_r <= S_STALL;
            else if (!run)
              st_r <= S_IDLE;
          end
        end
        S_STALL: if (endCyc) st_r <= S_RUN;
        S_SLEEP: if (wakeUp) st_r <= S_RUN;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (exec && push)
      stk[sp_r] <= pcInc;
  end

  // AXI4-Lite slave
  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  wire doWr = awHeld_r && wHeld_r && !bvalid_r;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `MID_CTRL_RST;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 5'h00;
      wData_r <= 8'h00;
      wStrb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `MID_RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r <= `MID_RESP_OK;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata[7:0];
        wStrb_r <= s_axi_wstrb[0];
      end
      if (doWr)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (awAddr_r[4:2] <= `MID_OFF_CONT >> 2) ?
          `MID_RESP_OK : `MID_RESP_ERR;
        if (awAddr_r[4:2] == `MID_OFF_CTRL >> 2 && wStrb_r)
          ctrl_r <= wData_r[3:0];
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_r <= 1'b1;
        rresp_r <= `MID_RESP_OK;
        case (s_axi_araddr[4:2])
          `MID_OFF_CTRL >> 2: rdata_r <= {28'h000_0000, ctrl_r};
          `MID_OFF_STAT >> 2: rdata_r <= {24'h00_0000,
            st_r == S_RUN, st_r == S_SLEEP, gie_r, stByte[4:0]};
          `MID_OFF_PC >> 2: rdata_r <= {{(32-PC_W){1'b0}}, pc_r};
          `MID_OFF_ACC >> 2: rdata_r <= {24'h00_0000, acc_r};
          `MID_OFF_CONT >> 2: rdata_r <= {24'h00_0000, cont_r};
          default:
          begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= `MID_RESP_ERR;
          end
        endcase
      end
      else if (rvalid_r && s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bresp = bresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign progAddr = pc_r;
  assign regAddr = regAddr_r;
  assign regWdata = regWdata_r;
  assign regWe = regWe_r;
  assign ctrlIdx = ctrlIdx_r;
  assign ctrlBank = bank;
  assign ctrlWdata = ctrlWdata_r;
  assign ctrlWe = ctrlWe_r;
  assign wdtClear = wdtClear_r;
  assign sleeping = (st_r == S_SLEEP);
  assign intEnable = gie_r;
endmodule

// ### hdl/mid_defs.vh
`ifndef MID_DEFS_VH
`define MID_DEFS_VH
// Register byte offsets
`define MID_OFF_CTRL 5'h00
`define MID_OFF_STAT 5'h04
`define MID_OFF_PC 5'h08
`define MID_OFF_ACC 5'h0c
`define MID_OFF_CONT 5'h10
// Control register bits and reset value
`define MID_CTRL_RUN 0
`define MID_CTRL_CYC 1
`define MID_CTRL_PER 2
`define MID_CTRL_BANK 3
`define MID_CTRL_RST 4'h6
`define MID_RESP_OK 2'h0
`define MID_RESP_ERR 2'h2
// Internal register indices and status bits
`define MID_REG_PC 6'h02
`define MID_REG_ST 6'h03
`define MID_ST_C 0
`define MID_ST_DC 1
`define MID_ST_Z 2
`define MID_ST_P 3
`define MID_ST_T 4
// Last phase index per instruction cycle
`define MID_PH_SHORT 2'h1
`define MID_PH_LONG 2'h3
// Special opcodes, low six bits with group zero
`define MID_OP_NOP 6'h00
`define MID_OP_DAA 6'h01
`define MID_OP_CTRL_WORD_WRITE_OP 6'h02
`define MID_OP_SLEEP 6'h03
`define MID_OP_WATCHDOG_CLEAR_OPCODE 6'h04
`define MID_OP_ENI 6'h10
`define MID_OP_DISI 6'h11
`define MID_OP_RET 6'h12
`define MID_OP_RETURN_FROM_IRQ 6'h13
`define MID_OP_CTRL_WORD_READ_OP 6'h14
// Opcode groups
`define MID_G_SPEC 4'h0
`define MID_G_SUB 4'h1
`define MID_G_ORAND 4'h2
`define MID_G_XADD 4'h3
`define MID_G_MOV 4'h4
`define MID_G_INC 4'h5
`define MID_G_ROT 4'h6
`define MID_G_SWAP 4'h7
`define MID_L_MOV 4'h8
`define MID_L_OR 4'h9
`define MID_L_AND 4'ha
`define MID_L_XOR 4'hb
`define MID_L_RETURN_WITH_LITERAL 4'hc
`define MID_L_SUB 4'hd
`define MID_L_ADD 4'hf
// Control register index window
`define MID_CR_LO 4'h5
`define MID_CR_HI0 4'hf
`define MID_CR_HI1 4'hc
// Decimal adjust
`define MID_BCD_NIB 4'h9
`define MID_BCD_BYTE 8'h99
`define MID_DAA_LO 8'h06
`define MID_DAA_HI 8'h60
`endif

// ### bench/mid_core_properties.sv
`timescale 1ns/1ps
module mid_core_props #(
  parameter PC_W = 12
) (
  input wire clk,
  input wire rst_n,
  input wire [PC_W-1:0] progAddr,
  input wire [5:0] regAddr,
  input wire regWe,
  input wire [3:0] ctrlIdx,
  input wire ctrlBank,
  input wire ctrlWe,
  input wire wdtClear,
  input wire sleeping,
  input wire wakeUp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_we_pulse;
    regWe |=> !regWe;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("register write pulse too long");
  property p_pc_gap;
    $changed(progAddr) |=> $stable(progAddr);
  endproperty
  a_pc_gap: assert property (p_pc_gap)
    else $error("program counter moved twice in a row");
  property p_internal;
    regWe |-> regAddr != 6'h02 && regAddr != 6'h03;
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal register written on the file port");
  property p_ctrl_range;
    ctrlWe |-> ctrlIdx >= 4'h5 && !(ctrlBank && ctrlIdx > 4'hc);
  endproperty
  a_ctrl_range: assert property (p_ctrl_range)
    else $error("control write to an absent index");
  property p_sleep_clr;
    $rose(sleeping) |-> wdtClear;
  endproperty
  a_sleep_clr: assert property (p_sleep_clr)
    else $error("sleep entered without watchdog clear");
  property p_sleep_hold;
    sleeping && !wakeUp |=> sleeping && $stable(progAddr);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("core left sleep on its own");
  property p_wake;
    sleeping && wakeUp |=> !sleeping;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request ignored");
  property p_wdt_pulse;
    wdtClear |=> !wdtClear;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse)
    else $error("watchdog clear pulse too long");
  c_sleep: cover property ($rose(sleeping));
  c_ctrl: cover property (ctrlWe);
  c_rf: cover property (regWe && regAddr == 6'h14);
endmodule

// ### bench/mid_mem_model.sv
`timescale 1ns/1ps
module mid_mem_model #(
  parameter PC_W = 12
) (
  input wire clk,
  input wire [PC_W-1:0] progAddr,
  output wire [12:0] progData,
  input wire [5:0] regAddr,
  output wire [7:0] regRdata,
  input wire [7:0] regWdata,
  input wire regWe,
  input wire [3:0] ctrlIdx,
  input wire ctrlBank,
  output wire [7:0] ctrlRdata,
  input wire [7:0] ctrlWdata,
  input wire ctrlWe
);
  reg [12:0] pm [0:(1<<PC_W)-1];
  reg [7:0] rf [0:63];
  reg [7:0] cr [0:31];
  // Whole instruction word per address
  assign progData = pm[progAddr];
  // Port registers answer like plain ones
  assign regRdata = rf[regAddr];
  assign ctrlRdata = cr[{ctrlBank, ctrlIdx}];
  always @(posedge clk)
  begin
    if (regWe)
      rf[regAddr] <= regWdata;
    if (ctrlWe)
      cr[{ctrlBank, ctrlIdx}] <= ctrlWdata;
  end
endmodule

// ### bench/tb_mid_core.sv
`timescale 1ns/1ps
module tb_mid_core;
  localparam PC_W = 12;
  reg clk = 1'h0;
  reg rst_n = 1'h0;
  reg awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
  reg arValid = 1'h0, rReady = 1'h0, wakeUp = 1'h0;
  reg [4:0] awAddr = 5'h00, arAddr = 5'h00;
  reg [31:0] wData = 32'h0000_0000;
  reg [31:0] rng = 32'h0000_003d;
  reg [PC_W-1:0] lastPc = 12'h000;
  wire awReady, wReady, bValid, arReady, rValid, regWe, ctrlBank, ctrlWe;
  wire wdtClear, sleeping, intEnable;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [PC_W-1:0] progAddr;
  wire [12:0] progData;
  wire [5:0] regAddr;
  wire [3:0] ctrlIdx;
  wire [7:0] regRdata, regWdata, ctrlRdata, ctrlWdata;
  integer miscompares = 0;
  integer checks = 0;
  integer cyc = 0;
  integer tAt [0:31];
  integer run, n, per;
  reg [7:0] v1, v2, v3, k4, v5;
  reg [2:0] b;
  reg [8:0] e10, e12;

  always #5 clk = ~clk;

  mid_core #(.PC_W(PC_W)) i_mid_core (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .progAddr(progAddr),
    .progData(progData), .regAddr(regAddr), .regRdata(regRdata),
    .regWdata(regWdata), .regWe(regWe), .ctrlIdx(ctrlIdx),
    .ctrlBank(ctrlBank), .ctrlRdata(ctrlRdata), .ctrlWdata(ctrlWdata),
    .ctrlWe(ctrlWe), .wdtClear(wdtClear), .sleeping(sleeping),
    .wakeUp(wakeUp), .intEnable(intEnable)
  );

  mid_mem_model #(.PC_W(PC_W)) i_mid_mem_model (
    .clk(clk), .progAddr(progAddr), .progData(progData),
    .regAddr(regAddr), .regRdata(regRdata), .regWdata(regWdata),
    .regWe(regWe), .ctrlIdx(ctrlIdx), .ctrlBank(ctrlBank),
    .ctrlRdata(ctrlRdata), .ctrlWdata(ctrlWdata), .ctrlWe(ctrlWe)
  );

  // Cycle stamp of each new program address
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    lastPc <= progAddr;
    if (progAddr !== lastPc)
      tAt[progAddr[4:0]] <= cyc;
  end

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  function [7:0] swp(input [7:0] v);
    swp = {v[3:0], v[7:4]};
  endfunction

  // Carry out on top, rotated byte below
  function [8:0] rot(input [7:0] v, input c, input lft);
    rot = lft ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task close_out;
    begin
      if (miscompares == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task ld(input integer a, input [12:0] w);
    i_mid_mem_model.pm[a] = w;
  endtask

  task st(input [5:0] a, input [7:0] v);
    i_mid_mem_model.rf[a] = v;
  endtask

  task axi_wr(input [4:0] a, input [31:0] d, input [1:0] er);
    reg done;
    begin
      done = 1'h0;
      @(posedge clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'h1;
      wValid <= 1'h1;
      bReady <= 1'h1;
      while (!done)
      begin
        @(posedge clk);
        if (awValid && awReady)
          awValid <= 1'h0;
        if (wValid && wReady)
          wValid <= 1'h0;
        if (bValid)
        begin
          done = 1'h1;
          chk(bResp, er);
          bReady <= 1'h0;
        end
      end
    end
  endtask

  task axi_rd(input [4:0] a, input [31:0] ed, input [1:0] er);
    reg done;
    begin
      done = 1'h0;
      @(posedge clk);
      arAddr <= a;
      arValid <= 1'h1;
      rReady <= 1'h1;
      while (!done)
      begin
        @(posedge clk);
        if (arValid && arReady)
          arValid <= 1'h0;
        if (rValid)
        begin
          done = 1'h1;
          chk(rData, ed);
          chk(rResp, er);
          rReady <= 1'h0;
        end
      end
    end
  endtask

  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    close_out;
  end

  initial
  begin
    for (run = 0; run < 2; run = run + 1)
    begin
      rst_n <= 1'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      rng = xs(rng);
      v1 = run ? rng[7:0] : 8'h01;
      v2 = run ? rng[15:8] : 8'h80;
      v3 = rng[23:16];
      k4 = rng[31:24];
      rng = xs(rng);
      b = run ? rng[2:0] : 3'h7;
      v5 = rng[15:8];
      per = run ? 2 : 4;
      e10 = rot(v1, 1'h0, 1'h0);
      e12 = rot(v2, e10[8], 1'h1);
      ld(0, 13'h1800 | v1);
      ld(1, 13'h0050);
      ld(2, 13'h0650);
      ld(3, 13'h06d2);
      ld(4, 13'h0713);
      ld(5, 13'h0054);
      ld(6, 13'h05d5);
      ld(7, 13'h00d9);
      ld(8, 13'h0e16 | (b << 6));
      ld(9, 13'h00d8);
      ld(10, 13'h1014);
      ld(11, 13'h0057);
      ld(12, 13'h0005);
      ld(13, 13'h1016);
      ld(14, 13'h1810);
      ld(15, 13'h0042);
      ld(16, 13'h0000);
      ld(17, 13'h0003);
      ld(18, 13'h1412);
      ld(20, 13'h1c00 | k4);
      ld(22, {5'h1a, ~k4});
      ld(23, 13'h0013);
      st(6'h12, v2);
      st(6'h13, v3);
      st(6'h15, 8'h01);
      st(6'h16, v5 | (8'h01 << b));
      st(6'h18, 8'h5a);
      st(6'h19, 8'ha5);
      i_mid_mem_model.cr[5'h05] = ~k4;
      axi_rd(5'h00, 32'h0000_0006, 2'h0);
      axi_wr(5'h08, 32'hffff_ffff, 2'h0);
      axi_rd(5'h08, 32'h0000_0000, 2'h0);
      axi_wr(5'h14, 32'h0000_0001, 2'h2);
      axi_rd(5'h18, 32'h0000_0000, 2'h2);
      axi_wr(5'h00, run ? 32'h0000_0001 : 32'h0000_0007, 2'h0);
      for (n = 0; n < 500 && sleeping !== 1'h1; n = n + 1)
        @(posedge clk);
      chk(sleeping, 1'h1);
      chk(progAddr, 12'h012);
      chk(tAt[15] - tAt[14], per);
      chk(tAt[17] - tAt[16], run ? per : 2 * per);
      chk(i_mid_mem_model.rf[6'h10], e10[7:0]);
      chk(i_mid_mem_model.rf[6'h12], e12[7:0]);
      chk(i_mid_mem_model.rf[6'h14], swp(v3));
      chk(i_mid_mem_model.rf[6'h15], 8'h00);
      chk(i_mid_mem_model.rf[6'h19], 8'ha5);
      chk(i_mid_mem_model.rf[6'h18], 8'h5a);
      chk(i_mid_mem_model.rf[6'h17], k4);
      chk(i_mid_mem_model.cr[5'h05], k4);
      chk(intEnable, 1'h1);
      axi_rd(5'h0c, 32'h0000_0010, 2'h0);
      axi_rd(5'h04, 32'h0000_0074 | e12[8], 2'h0);
      wakeUp <= 1'h1;
      @(posedge clk);
      wakeUp <= 1'h0;
      @(posedge clk);
      chk(sleeping, 1'h0);
    end
    close_out;
  end
endmodule

bind mid_core mid_core_props #(.PC_W(PC_W)) i_mid_core_props (
  .clk(clk), .rst_n(rst_n), .progAddr(progAddr), .regAddr(regAddr),
  .regWe(regWe), .ctrlIdx(ctrlIdx), .ctrlBank(ctrlBank), .ctrlWe(ctrlWe),
  .wdtClear(wdtClear), .sleeping(sleeping), .wakeUp(wakeUp)
);
